/* File: verilog/vtf_pkg.sv */
// Shared constants, types and helpers for the telemetry and fault-protection block
package vtf_pkg;
	localparam int CLK_PERIOD_NS   = 100;
	localparam int ALERT_MAX_NS    = 2000;
	localparam int ALERT_MAX_CYC   = ALERT_MAX_NS / CLK_PERIOD_NS;
	localparam int OC_TIMER_NS     = 9000;
	localparam int OC_CYC          = (OC_TIMER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PARTNER_MAX_NS  = 10000;
	localparam int PARTNER_MAX_CYC = PARTNER_MAX_NS / CLK_PERIOD_NS;
	localparam int UNBAL_NS        = 1000000;
	localparam int UNBAL_CYC       = (UNBAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0] OC_CNT_MAX = 7'(OC_CYC - 1);

	localparam int PKT_TFN_POS  = 21;
	localparam int PKT_CORE_POS = 6;
	localparam int PKT_NB_POS   = 7;
	localparam logic [2:0] SEL_VI  = 3'h5;
	localparam logic [2:0] SEL_V   = 3'h4;
	localparam logic [2:0] SEL_OFF = 3'h6;

	localparam logic [7:0] ADDR_PACKET = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_LOAD   = 8'h08;
	localparam int ST_LOW   = 0;
	localparam int ST_TRI   = 2;
	localparam int ST_OK    = 4;
	localparam int ST_ALERT = 6;
	localparam int ST_FAULT = 8;
	localparam int ST_MODE  = 10;
	localparam int ST_TOP   = 12;
	localparam int LD_CORE  = 0;
	localparam int LD_NB    = 8;

	localparam int SY_SVC   = 0;
	localparam int SY_EN    = 1;
	localparam int SY_POR   = 2;
	localparam int SY_OC    = 3;
	localparam int SY_WOC   = 5;
	localparam int SY_UNBAL = 7;
	localparam int SY_UV    = 9;
	localparam int SY_OV    = 11;
	localparam int SY_BELOW = 13;
	localparam int SYNC_W   = 15;

	localparam int FRAME_W = 34;
	localparam logic [5:0] FRAME_LAST = 6'h21;
	localparam logic [1:0] HDR_V  = 2'h2;
	localparam logic [1:0] HDR_VI = 2'h3;
	localparam logic [16:0] LOAD_CURRENT_MONITOR_FULL_CODE = 17'h00300;
	localparam logic [16:0] PCT_FULL       = 17'h00064;

	typedef enum logic [1:0] {TEL_OFF, TEL_V, TEL_VI} vtf_tel_mode_type;
	typedef enum logic [2:0] {SEQ_OFF, SEQ_RUN, SEQ_OV_PULL, SEQ_OV_TRI, SEQ_SHUT}
		vtf_seq_state_type;
	typedef logic [1:0][9:0] vtf_mon_pair_type;
	typedef logic [1:0][7:0] vtf_volt_pair_type;

	typedef struct packed {
		logic [SYNC_W-1:0]  s1;
		logic [SYNC_W-1:0]  s2;
		logic               svc_d;
		logic [31:0]        packet;
		vtf_tel_mode_type   mode;
		logic [FRAME_W-1:0] shift;
		logic [5:0]         bitcnt;
		logic               serial_telemetry_line;
		logic [31:0]        prdata;
		logic               pslverr;
	} vtf_top_reg_type;

	typedef struct packed {
		vtf_seq_state_type state;
		logic [6:0]        oc_cnt;
		logic [13:0]       unbal_cnt;
		logic              alert;
		logic              oc_tri;
	} vtf_seq_reg_type;

	localparam vtf_top_reg_type TOP_RST = vtf_top_reg_type'(0);
	localparam vtf_seq_reg_type SEQ_RST = vtf_seq_reg_type'(0);

	function automatic logic [7:0] vtf_load_pct(input logic [9:0] code);
		logic [16:0] prod;
		prod = {7'h00, code} * PCT_FULL;
		return 8'(prod / LOAD_CURRENT_MONITOR_FULL_CODE);
	endfunction
endpackage

/* File: verilog/vtf_seq_if.sv */
// Carrier between the top level and one output's fault sequencer
interface vtf_seq_if;
	logic                       en;
	logic                       oc;
	logic                       way_overcurrent_fault;
	logic                       unbal;
	logic                       uv;
	logic                       ov;
	logic                       below_vid;
	logic                       partner_fault;
	logic                       alert;
	logic                       phase_tri;
	logic                       low_on;
	logic                       output_ok;
	logic                       fault;
	vtf_pkg::vtf_seq_state_type state;
	modport seq (input en, oc, way_overcurrent_fault, unbal, uv, ov, below_vid, partner_fault,
		output alert, phase_tri, low_on, output_ok, fault, state);
	modport top (output en, oc, way_overcurrent_fault, unbal, uv, ov, below_vid, partner_fault,
		input alert, phase_tri, low_on, output_ok, fault, state);
endinterface

/* File: verilog/vtf_fault_seq.sv */
// Fault sequencer for one regulator output
module vtf_fault_seq #(
	parameter int UNBAL_CYC = vtf_pkg::UNBAL_CYC
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	vtf_seq_if.seq    sif
);
	import vtf_pkg::*;

	localparam logic [13:0] UNBAL_LAST = 14'(UNBAL_CYC - 1);

	vtf_seq_reg_type s_reg;
	vtf_seq_reg_type s_next;
	logic            unbal_trip;

	assign unbal_trip = sif.unbal && (s_reg.unbal_cnt == UNBAL_LAST);

	always_comb begin
		s_next = s_reg;
		s_next.alert = sif.oc;
		if (sif.oc) begin
			if (s_reg.oc_cnt != OC_CNT_MAX)
				s_next.oc_cnt = s_reg.oc_cnt + 7'h01;
		end else begin
			s_next.oc_cnt = 7'h00;
		end
		s_next.oc_tri = sif.oc && (s_reg.oc_cnt == OC_CNT_MAX);
		if (!sif.unbal)
			s_next.unbal_cnt = 14'h0000;
		else if (!unbal_trip)
			s_next.unbal_cnt = s_reg.unbal_cnt + 14'h0001;
		case (s_reg.state)
			SEQ_OFF: if (sif.en) s_next.state = SEQ_RUN;
			SEQ_RUN: begin
				// Latching faults outrank overvoltage: once tripped, nothing switches
				if (sif.way_overcurrent_fault || sif.uv || sif.partner_fault || unbal_trip)
					s_next.state = SEQ_SHUT;
				else if (sif.ov)
					s_next.state = SEQ_OV_PULL;
			end
			SEQ_OV_PULL: if (sif.below_vid) s_next.state = SEQ_OV_TRI;
			SEQ_OV_TRI: if (sif.ov) s_next.state = SEQ_OV_PULL;
			SEQ_SHUT: s_next.state = SEQ_SHUT;
			default: s_next.state = SEQ_OFF;
		endcase
		if (!sif.en)
			s_next = SEQ_RST;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			s_reg <= SEQ_RST;
		else
			s_reg <= s_next;
	end

	assign sif.alert     = s_reg.alert;
	assign sif.output_ok = s_reg.state == SEQ_RUN;
	assign sif.phase_tri = (s_reg.state != SEQ_RUN) || s_reg.oc_tri;
	assign sif.low_on    = s_reg.state == SEQ_OV_PULL;
	assign sif.fault     = s_reg.state inside {SEQ_SHUT, SEQ_OV_PULL, SEQ_OV_TRI};
	assign sif.state     = s_reg.state;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	oc_timer_a: assert property (
		(sif.en && sif.oc && s_reg.oc_cnt == OC_CNT_MAX) |=> sif.phase_tri)
		else $error("phases not tri-stated when overcurrent timer expired");
	oc_early_a: assert property (
		$rose(s_reg.oc_tri) |-> ($past(s_reg.oc_cnt) == OC_CNT_MAX && $past(sif.oc)))
		else $error("overcurrent tri-state before timer expiry");
	oc_clear_a: assert property (
		(sif.en && !sif.oc) |=> (s_reg.oc_cnt == 7'h00 && !sif.alert && !s_reg.oc_tri))
		else $error("overcurrent timer or alert not cleared");
	unbal_a: assert property (
		(sif.en && sif.unbal && s_reg.state == SEQ_RUN && s_reg.unbal_cnt == UNBAL_LAST)
		|=> (s_reg.state == SEQ_SHUT || !sif.en))
		else $error("current imbalance did not latch off");
	enable_clear_a: assert property (
		!sif.en |=> (s_reg.state == SEQ_OFF && !sif.alert && sif.phase_tri))
		else $error("faults not cleared while disabled");
endmodule

/* File: verilog/vtf_top.sv */
// Telemetry mode select, telemetry shifter, APB registers and two fault sequencers
// Summary of operation
// - Telemetry mode comes from packet bits 21, 6 and 7 together.
// - Pattern 1,0,1 sends voltage and current for both domains.
// - Pattern 1,0,0 sends voltage only; 1,1,0 disables; 1,1,1 reserved.
// - Telemetry leaves on the telemetry line, paced by the serial VID clock.
// - Reported load percentage scales with monitor voltage, 1.2V meaning full load.
// - Monitor at or above 1.5V flags an overcurrent event.
// - Thermal alert goes low within 2us of an overcurrent event.
// - A fault timer runs during overcurrent; at 7.5 to 11us phases tri-state.
// - Overcurrent clearing resets the timer and releases the thermal alert.
// - Undervoltage or way-overcurrent drops the affected output's power-good.
// - One output failing shuts the other down within 10us.
// - Way-overcurrent immediately tri-states phases, shuts down, drops power-good.
// - Way-overcurrent also shuts the other output down within 10us.
// - Phase imbalance above 9mV for 1ms latches the output off.
// - Output 325mV below target declares undervoltage, drops power-good, tri-states.
// - Output 325mV above target drops power-good and turns low-side switches on.
// - Low-side switches stay on until output falls below target, then tri-state.
// - Overvoltage returning after tri-state repeats the pull-down.
// - Enable toggle or power-on reset clears latched faults and restarts.
module vtf_top #(
	parameter int P_UNBAL_CYC = vtf_pkg::UNBAL_CYC
) (
	input  wire logic                       I_SYS_CLK,
	input  wire logic                       I_RST_N,
	input  wire logic                       I_PSEL,
	input  wire logic                       I_PENABLE,
	input  wire logic                       I_PWRITE,
	input  wire logic [7:0]                 I_PADDR,
	input  wire logic [31:0]                I_PWDATA,
	output      logic [31:0]                O_PRDATA,
	output      logic                       O_PREADY,
	output      logic                       O_PSLVERR,
	input  wire logic                       I_SERIAL_VID_CLOCK,
	output      logic                       O_SERIAL_TELEMETRY_LINE,
	input  wire logic                       I_ENABLE,
	input  wire logic                       I_POR_OK,
	input  wire logic [1:0]                 I_OC_CMP,
	input  wire logic [1:0]                 I_WOC_CMP,
	input  wire logic [1:0]                 I_UNBAL_CMP,
	input  wire logic [1:0]                 I_UV_CMP,
	input  wire logic [1:0]                 I_OV_CMP,
	input  wire logic [1:0]                 I_BELOW_VID_CMP,
	input  wire vtf_pkg::vtf_mon_pair_type  I_LOAD_MON_CODE,
	input  wire vtf_pkg::vtf_volt_pair_type I_VSENSE_CODE,
	output      logic                       O_THERMAL_ALERT_N,
	output      logic [1:0]                 O_OUTPUT_OK,
	output      logic [1:0]                 O_PHASE_TRI,
	output      logic [1:0]                 O_LOW_SIDE_ON
);
	import vtf_pkg::*;

	vtf_top_reg_type    r_reg;
	vtf_top_reg_type    r_next;
	logic [SYNC_W-1:0]  pins;
	logic               en_ok;
	logic               apb_setup;
	logic               apb_access;
	logic               svc_fall;
	logic               shift_msb;
	logic [1:0]         alert_v;
	logic [1:0]         fault_v;
	logic [1:0]         ok_v;
	logic [1:0]         tri_v;
	logic [1:0]         low_v;
	logic [1:0][7:0]    pct;
	logic [31:0]        status;
	logic [31:0]        load_word;
	logic [FRAME_W-1:0] frame;
	vtf_seq_state_type  state_v [2];

	function automatic vtf_tel_mode_type tel_decode(input logic [31:0] pkt,
		input vtf_tel_mode_type cur);
		case ({pkt[PKT_TFN_POS], pkt[PKT_CORE_POS], pkt[PKT_NB_POS]})
			SEL_VI: return TEL_VI;
			SEL_V: return TEL_V;
			SEL_OFF: return TEL_OFF;
			// Reserved pattern and function bit clear leave the mode alone
			default: return cur;
		endcase
	endfunction

	// Every comparator level and the enable, power-on and link clock pins cross into this clock by two flops
	assign pins = {I_BELOW_VID_CMP, I_OV_CMP, I_UV_CMP, I_UNBAL_CMP, I_WOC_CMP,
		I_OC_CMP, I_POR_OK, I_ENABLE, I_SERIAL_VID_CLOCK};
	assign en_ok = r_reg.s2[SY_EN] && r_reg.s2[SY_POR];
	assign svc_fall = r_reg.svc_d && !r_reg.s2[SY_SVC];
	assign shift_msb = r_reg.shift[FRAME_W-1];
	assign apb_setup = I_PSEL && !I_PENABLE;
	assign apb_access = I_PSEL && I_PENABLE;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ch
			vtf_seq_if sif ();
			assign sif.en = en_ok;
			assign sif.oc = r_reg.s2[SY_OC + gi];
			assign sif.way_overcurrent_fault = r_reg.s2[SY_WOC + gi];
			assign sif.unbal = r_reg.s2[SY_UNBAL + gi];
			assign sif.uv = r_reg.s2[SY_UV + gi];
			assign sif.ov = r_reg.s2[SY_OV + gi];
			assign sif.below_vid = r_reg.s2[SY_BELOW + gi];
			assign sif.partner_fault = fault_v[1 - gi];
			assign alert_v[gi] = sif.alert;
			assign fault_v[gi] = sif.fault;
			assign ok_v[gi] = sif.output_ok;
			assign tri_v[gi] = sif.phase_tri;
			assign low_v[gi] = sif.low_on;
			assign state_v[gi] = sif.state;
			assign pct[gi] = vtf_load_pct(I_LOAD_MON_CODE[gi]);
			vtf_fault_seq #(
				.UNBAL_CYC(P_UNBAL_CYC)
			) u_seq (
				.i_clk  (I_SYS_CLK),
				.i_rst_n(I_RST_N),
				.sif    (sif)
			);
		end
	endgenerate

	assign status[ST_LOW +: 2]   = low_v;
	assign status[ST_TRI +: 2]   = tri_v;
	assign status[ST_OK +: 2]    = ok_v;
	assign status[ST_ALERT +: 2] = alert_v;
	assign status[ST_FAULT +: 2] = fault_v;
	assign status[ST_MODE +: 2]  = r_reg.mode;
	assign status[31:ST_TOP]     = '0;
	assign load_word[LD_CORE +: 8] = pct[0];
	assign load_word[LD_NB +: 8]   = pct[1];
	assign load_word[31:16]        = 16'h0000;

	// Current fields are zero in voltage-only mode so the frame length never changes
	always_comb begin
		frame = '0;
		case (r_reg.mode)
			TEL_V: frame = {HDR_V, I_VSENSE_CODE[0], 8'h00,
				I_VSENSE_CODE[1], 8'h00};
			TEL_VI: frame = {HDR_VI, I_VSENSE_CODE[0], pct[0],
				I_VSENSE_CODE[1], pct[1]};
			default: frame = '0;
		endcase
	end

	always_comb begin
		r_next = r_reg;
		r_next.s1 = pins;
		r_next.s2 = r_reg.s1;
		r_next.svc_d = r_reg.s2[SY_SVC];
		// Read data is captured in the setup cycle so it comes from a flop
		if (apb_setup) begin
			r_next.pslverr = 1'b0;
			case (I_PADDR)
				ADDR_PACKET: r_next.prdata = r_reg.packet;
				ADDR_STATUS: begin
					r_next.prdata = status;
					r_next.pslverr = I_PWRITE;
				end
				ADDR_LOAD: begin
					r_next.prdata = load_word;
					r_next.pslverr = I_PWRITE;
				end
				default: begin
					r_next.prdata = 32'h00000000;
					r_next.pslverr = 1'b1;
				end
			endcase
		end
		if (apb_access && I_PWRITE && I_PADDR == ADDR_PACKET) begin
			r_next.packet = I_PWDATA;
			r_next.mode = tel_decode(I_PWDATA, r_reg.mode);
		end
		// Bits change on the falling link clock so the far end samples a settled line
		if (svc_fall) begin
			if (r_reg.mode == TEL_OFF) begin
				r_next.serial_telemetry_line = 1'b0;
				r_next.bitcnt = 6'h00;
			end else if (r_reg.bitcnt == 6'h00) begin
				r_next.serial_telemetry_line = frame[FRAME_W-1];
				r_next.shift = {frame[FRAME_W-2:0], 1'b0};
				r_next.bitcnt = FRAME_LAST;
			end else begin
				r_next.serial_telemetry_line = shift_msb;
				r_next.shift = {r_reg.shift[FRAME_W-2:0], 1'b0};
				r_next.bitcnt = r_reg.bitcnt - 6'h01;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N)
			r_reg <= TOP_RST;
		else
			r_reg <= r_next;
	end

	assign O_PRDATA = r_reg.prdata;
	assign O_PSLVERR = r_reg.pslverr && apb_access;
	assign O_PREADY = apb_access;
	assign O_SERIAL_TELEMETRY_LINE = r_reg.serial_telemetry_line;
	assign O_THERMAL_ALERT_N = !(|alert_v);
	assign O_OUTPUT_OK = ok_v;
	assign O_PHASE_TRI = tri_v;
	assign O_LOW_SIDE_ON = low_v;

	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_N);

	sequence pkt_write(logic [2:0] sel);
		apb_access && I_PWRITE && I_PADDR == ADDR_PACKET &&
		{I_PWDATA[PKT_TFN_POS], I_PWDATA[PKT_CORE_POS], I_PWDATA[PKT_NB_POS]} == sel;
	endsequence

	vi_mode_a: assert property (pkt_write(SEL_VI) |=> r_reg.mode == TEL_VI)
		else $error("voltage and current mode not selected");
	volt_mode_a: assert property (pkt_write(SEL_V) |=> r_reg.mode == TEL_V)
		else $error("voltage-only mode not selected");
	tel_off_a: assert property (pkt_write(SEL_OFF) |=> r_reg.mode == TEL_OFF)
		else $error("telemetry not disabled");
	rsvd_keep_a: assert property (
		pkt_write(3'h7) |=> r_reg.mode == $past(r_reg.mode))
		else $error("reserved pattern changed telemetry mode");
	tel_idle_a: assert property (
		(svc_fall && r_reg.mode == TEL_OFF) |=> !O_SERIAL_TELEMETRY_LINE)
		else $error("telemetry line active while disabled");
	tel_shift_a: assert property (
		(svc_fall && r_reg.mode != TEL_OFF && r_reg.bitcnt != 6'h00)
		|=> O_SERIAL_TELEMETRY_LINE == $past(shift_msb))
		else $error("telemetry bit out of order");
	load_scale_a: assert property (
		I_LOAD_MON_CODE[0] == LOAD_CURRENT_MONITOR_FULL_CODE[9:0] |-> pct[0] == PCT_FULL[7:0])
		else $error("full-scale monitor does not read as full load");
	alert_time_a: assert property (
		(g_ch[0].sif.oc && en_ok) |-> ##[1:2] !O_THERMAL_ALERT_N)
		else $error("thermal alert late after overcurrent");

	sequence run_core;
		state_v[0] == SEQ_RUN && en_ok;
	endsequence
	sequence ov_pulling;
		state_v[0] == SEQ_OV_PULL && en_ok && !r_reg.s2[SY_BELOW];
	endsequence

	uv_shut_a: assert property (
		(run_core and r_reg.s2[SY_UV]) |=> (O_PHASE_TRI[0] && !O_OUTPUT_OK[0]))
		else $error("undervoltage did not drop power-good");
	woc_shut_a: assert property (
		(run_core and r_reg.s2[SY_WOC]) |=> (O_PHASE_TRI[0] && !O_OUTPUT_OK[0]))
		else $error("way-overcurrent did not shut down");
	partner_a: assert property (
		(fault_v[1] && en_ok) |-> ##[1:2] !O_OUTPUT_OK[0])
		else $error("other output not shut down after fault");
	ov_enter_a: assert property (
		(run_core and r_reg.s2[SY_OV]) |=> (!O_OUTPUT_OK[0] &&
		state_v[0] inside {SEQ_OV_PULL, SEQ_SHUT, SEQ_OFF}))
		else $error("overvoltage did not start pull-down");
	ov_hold_a: assert property (
		ov_pulling |=> (O_LOW_SIDE_ON[0] || !en_ok))
		else $error("low-side switches released too early");
	ov_release_a: assert property (
		(state_v[0] == SEQ_OV_PULL && en_ok && r_reg.s2[SY_BELOW])
		|=> (!O_LOW_SIDE_ON[0] && O_PHASE_TRI[0]))
		else $error("lower gate not tri-stated below target");
	ov_repeat_a: assert property (
		(state_v[0] == SEQ_OV_TRI && en_ok && r_reg.s2[SY_OV]) |=> O_LOW_SIDE_ON[0])
		else $error("overvoltage pull-down not repeated");
endmodule

/* File: test/vtf_host_model.sv */
// Processor-side model: paces the link clock and collects one telemetry frame
module vtf_host_model (
	input  wire logic i_clk,
	input  wire logic i_line,
	output logic      o_svc
);
	timeunit 1ns;
	timeprecision 1ns;

	// Link clock idles high and only toggles inside a frame
	initial o_svc = 1'b1;

	// Link edges move only on system clock edges, four cycles a phase for 800 ns;
	// each bit is taken just before the next fall, long after the line has settled
	task automatic read_frame(output logic [33:0] f);
		@(posedge i_clk);
		for (int i = 33; i >= 0; i--) begin
			o_svc <= 1'b0;
			repeat (4) @(posedge i_clk);
			o_svc <= 1'b1;
			repeat (4) @(posedge i_clk);
			f[i] = i_line;
		end
	endtask
endmodule

/* File: test/tb.sv */
// Self-checking bench for the telemetry and fault-protection block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import vtf_pkg::*;

	localparam int UNBAL = 20;

	logic              clk     = 1'b0;
	logic              rst_n   = 1'b0;
	logic              psel    = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite  = 1'b0;
	logic              en      = 1'b0;
	logic              por     = 1'b0;
	logic [7:0]        paddr   = 8'h00;
	logic [31:0]       pwdata  = 32'h00000000;
	logic [1:0]        oc      = 2'h0;
	logic [1:0]        way_overcurrent_fault     = 2'h0;
	logic [1:0]        unbal   = 2'h0;
	logic [1:0]        uv      = 2'h0;
	logic [1:0]        ov      = 2'h0;
	logic [1:0]        below   = 2'h0;
	vtf_mon_pair_type  mon     = {10'h17F, 10'h300};
	vtf_volt_pair_type vs      = {8'h5A, 8'hA3};
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              serial_vid_clock;
	logic              tline;
	logic              alert_n;
	logic [1:0]        ok;
	logic [1:0]        tri_o;
	logic [1:0]        low;
	logic [31:0]       rd;
	logic              err;
	logic [33:0]       fr;
	int                n_mismatch = 0;
	int                n_checks   = 0;
	int                n;
	int                t;
	int                p0;
	int                p1;
	logic [2:0]        pat [5] = '{3'h4, 3'h6, 3'h7, 3'h5, 3'h1};
	logic [1:0]        me  [5] = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h2};
	wire  [6:0]        watch = {low, tri_o, ok, alert_n};

	always #50 clk = ~clk;

	vtf_top #(.P_UNBAL_CYC(UNBAL)) u_vtf_top (
		.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_SERIAL_VID_CLOCK(serial_vid_clock),
		.O_SERIAL_TELEMETRY_LINE(tline), .I_ENABLE(en), .I_POR_OK(por),
		.I_OC_CMP(oc), .I_WOC_CMP(way_overcurrent_fault), .I_UNBAL_CMP(unbal), .I_UV_CMP(uv),
		.I_OV_CMP(ov), .I_BELOW_VID_CMP(below), .I_LOAD_MON_CODE(mon),
		.I_VSENSE_CODE(vs), .O_THERMAL_ALERT_N(alert_n), .O_OUTPUT_OK(ok),
		.O_PHASE_TRI(tri_o), .O_LOW_SIDE_ON(low)
	);

	vtf_host_model u_vtf_host_model (
		.i_clk (clk),
		.i_line(tline),
		.o_svc (serial_vid_clock)
	);

	task automatic summarize;
		if (n_mismatch == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic tmo;
		n_mismatch++;
		$display("BAD %0t wait ran out", $time);
		summarize();
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %0h expected %0h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request holds until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
			if (k > 20)
				tmo();
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Counts settled edges until one watched output takes a level
	task automatic wait_sig(input int idx, input logic v, input int maxc);
		n = 0;
		while (watch[idx] !== v) begin
			@(posedge clk);
			#1;
			n++;
			if (n > maxc)
				tmo();
		end
	endtask

	task automatic recover(input logic use_por);
		@(posedge clk);
		{oc, way_overcurrent_fault, unbal, uv, ov, below} <= 12'h000;
		if (use_por)
			por <= 1'b0;
		else
			en <= 1'b0;
		repeat (5) @(posedge clk);
		por <= 1'b1;
		en <= 1'b1;
		wait_sig(1, 1'b1, 10);
		chk({ok, tri_o, low}, 6'h30);
	endtask

	function automatic logic [31:0] pk(input logic [2:0] p);
		pk = 32'h00000000;
		pk[PKT_TFN_POS] = p[2];
		pk[PKT_CORE_POS] = p[1];
		pk[PKT_NB_POS] = p[0];
	endfunction

	initial begin
		#4000000;
		tmo();
	end

	initial begin
		p0 = 32'h300 * 100 / 768;
		p1 = 32'h17F * 100 / 768;
		repeat (4) @(posedge clk);
		#1;
		chk({alert_n, ok, tri_o, low, tline}, 8'h98);
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, ADDR_PACKET, 32'h0);
		chk(rd, 32'h0);
		@(posedge clk);
		en <= 1'b1;
		por <= 1'b1;
		wait_sig(1, 1'b1, 8);
		chk({ok, tri_o}, 4'hC);
		apb(1'b0, 8'h0C, 32'h0);
		chk({err, rd}, 33'h100000000);
		apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
		chk(err, 1'b1);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, ADDR_PACKET, pk(pat[i]));
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk(rd[ST_MODE+:2], me[i]);
			if (me[i] == 2'h0)
				chk(tline, 1'b0);
		end
		apb(1'b0, ADDR_LOAD, 32'h0);
		chk(rd[15:0], {p1[7:0], p0[7:0]});
		u_vtf_host_model.read_frame(fr);
		chk(fr, {2'b11, vs[0], p0[7:0], vs[1], p1[7:0]});
		apb(1'b1, ADDR_PACKET, pk(3'h4));
		u_vtf_host_model.read_frame(fr);
		chk(fr, {2'b10, vs[0], 8'h00, vs[1], 8'h00});
		apb(1'b1, ADDR_PACKET, pk(3'h6));
		u_vtf_host_model.read_frame(fr);
		chk(fr, 34'h000000000);
		@(posedge clk);
		oc[0] <= 1'b1;
		wait_sig(0, 1'b0, 25);
		t = n;
		chk(t <= ALERT_MAX_CYC, 1'b1);
		wait_sig(3, 1'b1, 120);
		chk((t + n) >= 75 && (t + n) <= 110, 1'b1);
		@(posedge clk);
		oc[0] <= 1'b0;
		wait_sig(0, 1'b1, 10);
		wait_sig(3, 1'b0, 10);
		chk(ok, 2'h3);
		// Two bursts each under the timer: a timer that fails to clear would trip
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			oc[0] <= 1'b1;
			repeat (60) @(posedge clk);
			oc[0] <= 1'b0;
			repeat (10) @(posedge clk);
		end
		#1;
		chk({tri_o, alert_n}, 3'h1);
		@(posedge clk);
		way_overcurrent_fault[0] <= 1'b1;
		wait_sig(1, 1'b0, 4);
		chk(tri_o[0], 1'b1);
		wait_sig(2, 1'b0, 100);
		chk(ok, 2'h0);
		recover(1'b0);
		@(posedge clk);
		uv[1] <= 1'b1;
		wait_sig(2, 1'b0, 4);
		chk(tri_o[1], 1'b1);
		wait_sig(1, 1'b0, 100);
		chk(ok, 2'h0);
		recover(1'b1);
		@(posedge clk);
		unbal[0] <= 1'b1;
		repeat (10) @(posedge clk);
		unbal[0] <= 1'b0;
		repeat (10) @(posedge clk);
		#1;
		chk(ok[0], 1'b1);
		@(posedge clk);
		unbal[0] <= 1'b1;
		wait_sig(1, 1'b0, 40);
		chk(n >= UNBAL && n <= UNBAL + 6, 1'b1);
		recover(1'b0);
		@(posedge clk);
		ov[0] <= 1'b1;
		wait_sig(5, 1'b1, 4);
		chk(ok[0], 1'b0);
		@(posedge clk);
		ov[0] <= 1'b0;
		repeat (10) @(posedge clk);
		#1;
		chk(low[0], 1'b1);
		@(posedge clk);
		below[0] <= 1'b1;
		wait_sig(5, 1'b0, 4);
		chk(tri_o[0], 1'b1);
		@(posedge clk);
		below[0] <= 1'b0;
		ov[0] <= 1'b1;
		wait_sig(5, 1'b1, 4);
		chk(low[0], 1'b1);
		recover(1'b1);
		summarize();
	end
endmodule
